/* agcd_debounce.sv */
`timescale 1ns/100ps
`include "agcd_regs.svh"

module agcd_debounce
    import agcd_pkg::*;
#(
    parameter int NOISE_BIG_UNIT = `AGCD_NOISE_BIG_UNIT,
    parameter int SIGNAL_BIG_UNIT = `AGCD_SIGNAL_BIG_UNIT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // register access port
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // level detector side
    input wire logic adc_fs_tick,
    input wire logic noise_raw,
    input wire logic [4:0] noise_thr_code,
    // gain loop side
    output logic noise_state,
    output logic hold_busy
);

    agcd_cfg_s cfg_q;
    agcd_cfg_s cfg_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    agcd_state_e state_q;
    agcd_state_e state_d;
    agcd_cnt_t cnt_q;
    agcd_cnt_t cnt_d;
    agcd_cnt_t noise_tgt_q;
    agcd_cnt_t noise_tgt_d;
    agcd_cnt_t signal_tgt_q;
    agcd_cnt_t signal_tgt_d;
    agcd_cnt_t target;
    agcd_cnt_t cnt_inc;
    logic det_en;
    logic differs;
    logic busy_q;
    logic busy_d;
    agcd_state_e other;

    // noise decode, one row per short code
    function automatic agcd_cnt_t noise_hold(input logic [4:0] code);
        agcd_cnt_t base;
        agcd_cnt_t r;
        base = agcd_cnt_t'(`AGCD_HOLD_BASE);
        r = '0;
        case (code)
            5'h00: r = '0;
            5'h01: r = base;
            5'h02: r = base << 1;
            5'h03: r = base << 2;
            5'h04: r = base << 3;
            // gap code read as the missing power of two
            5'h05: r = base << 4;
            5'h06: r = base << 5;
            5'h07: r = base << 6;
            5'h08: r = base << 7;
            5'h09: r = base << 8;
            5'h0a: r = base << 9;
            default: begin
                r = agcd_cnt_t'((32'(code) - `AGCD_NOISE_BIG_BASE) * NOISE_BIG_UNIT);
            end
        endcase
        return r;
    endfunction : noise_hold

    // signal decode, one row per short code
    function automatic agcd_cnt_t signal_hold(input logic [3:0] code);
        agcd_cnt_t base;
        agcd_cnt_t r;
        base = agcd_cnt_t'(`AGCD_HOLD_BASE);
        r = '0;
        case (code)
            4'h0: r = '0;
            4'h1: r = base;
            4'h2: r = base << 1;
            4'h3: r = base << 2;
            4'h4: r = base << 3;
            // gap code read as the missing power of two
            4'h5: r = base << 4;
            4'h6: r = base << 5;
            4'h7: r = base << 6;
            4'h8: r = base << 7;
            4'h9: r = base << 8;
            default: begin
                r = agcd_cnt_t'((32'(code) - `AGCD_SIGNAL_BIG_BASE) * SIGNAL_BIG_UNIT);
            end
        endcase
        return r;
    endfunction : signal_hold

    // register file
    always_comb begin
        cfg_d = cfg_q;
        rdata_d = 8'h00;
        if (reg_wr) begin
            if (reg_addr == `AGCD_NOISE_HOLD_OFS) begin
                cfg_d.noise_code = reg_wdata[`AGCD_NOISE_CODE_W-1:0];
            end else if (reg_addr == `AGCD_SIGNAL_HOLD_OFS) begin
                cfg_d.signal_code = reg_wdata[`AGCD_SIGNAL_CODE_W-1:0];
            end
        end
        // reserved bits read as zero
        if (reg_addr == `AGCD_NOISE_HOLD_OFS) begin
            rdata_d = {3'h0, cfg_q.noise_code};
        end else if (reg_addr == `AGCD_SIGNAL_HOLD_OFS) begin
            rdata_d = {4'h0, cfg_q.signal_code};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cfg_q <= '{noise_code: `AGCD_NOISE_RESET, signal_code: `AGCD_SIGNAL_RESET};
            rdata_q <= 8'h00;
        end else if (ce) begin
            cfg_q <= cfg_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // targets registered so the shift and multiply stay off the per-sample
    // compare path; decoded from cfg_d, so they change with the codes
    always_comb begin
        noise_tgt_d = noise_hold(cfg_d.noise_code);
        signal_tgt_d = signal_hold(cfg_d.signal_code);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            // both codes reset to zero, which decodes to no hold
            noise_tgt_q <= '0;
            signal_tgt_q <= '0;
        end else if (ce) begin
            noise_tgt_q <= noise_tgt_d;
            signal_tgt_q <= signal_tgt_d;
        end
    end

    // debounce engine
    always_comb begin
        // a code rewritten mid-count applies from the next sample; the count is kept
        // detection off at zero threshold
        det_en = (noise_thr_code != 5'h00);
        differs = 1'b0;
        target = '0;
        cnt_inc = cnt_q + agcd_cnt_t'(1);
        state_d = state_q;
        cnt_d = cnt_q;
        other = AGCD_SIGNAL;
        case (state_q)
            AGCD_SIGNAL: begin
                // entering noise is timed by the noise code
                differs = noise_raw;
                target = noise_tgt_q;
                other = AGCD_NOISE;
            end
            AGCD_NOISE: begin
                // leaving noise is timed by the signal code
                differs = !noise_raw;
                target = signal_tgt_q;
                other = AGCD_SIGNAL;
            end
            default: begin
                differs = 1'b0;
                target = '0;
                other = AGCD_SIGNAL;
            end
        endcase
        if (!det_en) begin
            state_d = AGCD_SIGNAL;
            cnt_d = '0;
        end else if (adc_fs_tick) begin
            if (!differs) begin
                cnt_d = '0;
            end else if (cnt_inc >= target) begin
                state_d = other;
                cnt_d = '0;
            end else begin
                cnt_d = cnt_inc;
            end
        end
        busy_d = (cnt_d != '0);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= AGCD_SIGNAL;
            cnt_q <= '0;
            busy_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            busy_q <= busy_d;
        end
    end

    // busy while a candidate change is being timed, not just on a raw blip
    assign noise_state = (state_q == AGCD_NOISE);
    assign hold_busy = busy_q;

endmodule : agcd_debounce

/* agcd_regs.svh */
`ifndef AGCD_REGS_SVH
`define AGCD_REGS_SVH

// register offsets
`define AGCD_NOISE_HOLD_OFS 8'h5b
`define AGCD_SIGNAL_HOLD_OFS 8'h5c

// field layout
`define AGCD_NOISE_CODE_W 5
`define AGCD_SIGNAL_CODE_W 4
`define AGCD_NOISE_RESET 5'h00
`define AGCD_SIGNAL_RESET 4'h0

// hold-time table corners and counter width; base and big units in sample periods, last and big-base values are codes
`define AGCD_HOLD_BASE 4
`define AGCD_NOISE_POW2_LAST 5'h0a
`define AGCD_SIGNAL_POW2_LAST 4'h9
`define AGCD_NOISE_BIG_UNIT 4096
`define AGCD_SIGNAL_BIG_UNIT 2048
`define AGCD_NOISE_BIG_BASE 10
`define AGCD_SIGNAL_BIG_BASE 8
`define AGCD_CNT_W 17

`endif

/* agcd_pkg.sv */
`include "agcd_regs.svh"

package agcd_pkg;

    typedef enum logic [0:0] {
        AGCD_SIGNAL = 1'b0,
        AGCD_NOISE = 1'b1
    } agcd_state_e;

    typedef struct packed {
        logic [`AGCD_NOISE_CODE_W-1:0] noise_code;
        logic [`AGCD_SIGNAL_CODE_W-1:0] signal_code;
    } agcd_cfg_s;

    typedef logic [`AGCD_CNT_W-1:0] agcd_cnt_t;

endpackage : agcd_pkg

/* agcd_checker.sv */
`timescale 1ns/100ps
module agcd_checker (
    // watched ports
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic adc_fs_tick,
    input wire logic noise_raw,
    input wire logic [4:0] noise_thr_code,
    input wire logic noise_state,
    input wire logic hold_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_same_tick;
        ce && adc_fs_tick && noise_thr_code != 5'h00 && noise_raw == noise_state;
    endsequence
    a_noise_rsv_zero: assert property (ce && reg_addr == 8'h5b |=> reg_rdata[7:5] == 3'h0)
        else $error("noise register upper bits not zero");
    a_signal_rsv_zero: assert property (ce && reg_addr == 8'h5c |=> reg_rdata[7:4] == 4'h0)
        else $error("signal register upper bits not zero");
    a_unmapped_read: assert property (ce && reg_addr != 8'h5b && reg_addr != 8'h5c
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_thr_off: assert property (ce && noise_thr_code == 5'h00 |=> !noise_state && !hold_busy)
        else $error("detection not off at zero threshold");
    a_tick_only: assert property (ce && !adc_fs_tick && noise_thr_code != 5'h00
        |=> $stable(noise_state)) else $error("state moved without sample tick");
    a_lapse_clear: assert property (s_same_tick |=> !hold_busy && $stable(noise_state))
        else $error("count not restarted on lapse");
    a_ce_freeze: assert property (!ce |=> $stable(noise_state) && $stable(reg_rdata))
        else $error("state moved while frozen");
    a_flip_cause: assert property ($changed(noise_state) |-> $past(adc_fs_tick)
        || $past(noise_thr_code) == 5'h00) else $error("flip without tick");
endmodule : agcd_checker
bind agcd_debounce agcd_checker i_chk (.clk(clk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .adc_fs_tick(adc_fs_tick), .noise_raw(noise_raw),
    .noise_thr_code(noise_thr_code), .noise_state(noise_state), .hold_busy(hold_busy));

/* tb.sv */
`timescale 1ns/100ps
module tb;
    localparam int NB = 16;
    localparam int SB = 8;
    logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, reg_wr = 1'b0, adc_fs_tick = 1'b0, noise_raw = 1'b0;
    logic [7:0] reg_addr = 8'h5b, reg_wdata = 8'h00, reg_rdata;
    logic [4:0] noise_thr_code = 5'h01;
    logic noise_state, hold_busy;
    int bad_count = 0, comparisons = 0, n;
    logic [7:0] nc[7] = '{8'h00, 8'h01, 8'h04, 8'h06, 8'h07, 8'h1e, 8'h1f};
    logic [7:0] sc[7] = '{8'h00, 8'h01, 8'h04, 8'h06, 8'h09, 8'h0c, 8'h07};
    int nexp[7] = '{1, 4, 32, 128, 256, 20 * NB, 21 * NB};
    int sexp[7] = '{1, 4, 32, 128, 1024, 4 * SB, 256};
    always #50 clk = ~clk;
    agcd_debounce #(.NOISE_BIG_UNIT(NB), .SIGNAL_BIG_UNIT(SB)) i_dut (.clk(clk), .rst_b(rst_b),
        .ce(ce), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .adc_fs_tick(adc_fs_tick), .noise_raw(noise_raw),
        .noise_thr_code(noise_thr_code), .noise_state(noise_state), .hold_busy(hold_busy));
    task automatic close_out;
        $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk
    // read back twice later since rdata trails the address by a cycle
    task automatic wr(input logic [7:0] a, d, e);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        repeat (2) @(negedge clk);
        chk("rdata", e, reg_rdata);
    endtask : wr
    // ticks every cycle; n ends as the number of ticks taken to flip
    task automatic run(input logic dir, output int n);
        noise_raw = dir;
        adc_fs_tick = 1'b1;
        n = 0;
        while (noise_state !== dir && n < 3000) begin
            @(negedge clk);
            n++;
        end
        adc_fs_tick = 1'b0;
    endtask : run
    task automatic t_regs;
        chk("rst_rdata", 8'h00, reg_rdata);
        wr(8'h5b, 8'h1f, 8'h1f);
        wr(8'h5c, 8'h0f, 8'h0f);
        wr(8'h5d, 8'h55, 8'h00);
    endtask : t_regs
    task automatic t_table;
        for (int i = 0; i < 7; i++) begin
            wr(8'h5b, nc[i], nc[i]);
            wr(8'h5c, sc[i], sc[i]);
            run(1'b1, n);
            chk("noise_hold", nexp[i], n);
            run(1'b0, n);
            chk("signal_hold", sexp[i], n);
        end
    endtask : t_table
    task automatic t_lapse;
        wr(8'h5b, 8'h01, 8'h01);
        noise_raw = 1'b1;
        adc_fs_tick = 1'b1;
        repeat (2) @(negedge clk);
        chk("busy", 1'b1, hold_busy);
        noise_raw = 1'b0;
        @(negedge clk);
        chk("busy_clr", 1'b0, hold_busy);
        run(1'b1, n);
        chk("restart", 4, n);
        run(1'b0, n);
    endtask : t_lapse
    task automatic t_off;
        noise_thr_code = 5'h00;
        noise_raw = 1'b1;
        adc_fs_tick = 1'b1;
        repeat (8) @(negedge clk);
        chk("thr_off", 1'b0, noise_state);
        noise_thr_code = 5'h01;
        ce = 1'b0;
        repeat (8) @(negedge clk);
        chk("frozen", 1'b0, noise_state);
        ce = 1'b1;
        adc_fs_tick = 1'b0;
    endtask : t_off
    initial begin
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        t_regs();
        t_table();
        t_lapse();
        t_off();
        close_out();
    end
    initial begin
        #2000000;
        bad_count++;
        close_out();
    end
endmodule : tb
